// ---- breaker_command_control.sv ----
// command control for one circuit breaker, APB register access
// assumes: pins asynchronous to pclk, APB master on pclk
//
// What this block does
// (RQ1) local requests only with local permit
// (RQ2) remote requests only with remote permit
// (RQ3) open pulse only with open interlock ok
// (RQ4) close pulse only with close interlock ok
// (RQ5) process block refuses commands, stops pulses
// (RQ6) close needs sync ok, tie true otherwise
// (RQ7) three control schemes, direct normal default
// (RQ8) forced check overrides request skip attribute
// (RQ9) enhanced: position must change within limit
// (RQ10) command pulse of settable length
// (RQ11) pulse ends early on success, not below minimum
// (RQ12) intermediate status reported after settable wait
// (RQ13) close without sync waits, then switch procedure
// (RQ14) switch wait expiry returns idle, no switching
// (RQ15) zero switch wait never raises switch start
// (RQ16) select expires unless operate follows in time
// (RQ17) outside command only masks unintended operation
// (RQ18) breaker gives separate opened and closed contacts
// (RQ19) 150 ms operation pulse, counted per start
// (RQ20) flag position change without any command
// (RQ21) four-valued position status from two contacts
// (RQ22) timers run on ms tick, clear synchronously
// (RQ23) one command at a time, others rejected
`timescale 1ns/10ps
`include "brk_defines.svh"
module breaker_command_control #(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [7:0]            paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output wire logic                  pready,
   output wire logic                  pslverr,
   input  wire logic                  local_permit,
   input  wire logic                  remote_permit,
   input  wire logic                  sync_ok,
   input  wire logic                  open_interlock_ok,
   input  wire logic                  close_interlock_ok,
   input  wire logic                  process_block,
   input  wire logic                  outside_command_seen,
   input  wire logic                  pos_opened_in,
   input  wire logic                  pos_closed_in,
   output logic                       open_pulse_out,
   output logic                       close_pulse_out,
   output logic                       sync_switch_start,
   output logic                       oper_pulse,
   output logic                       unintended_operation,
   output logic                       invalid_pos_err,
   output brk_pkg::pos_status_type    pos_status
);
   import brk_pkg::*;

   brk_time_if t ();

   ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .t       (t.gen)
   );

   pos_supervisor u_pos (
      .pclk          (pclk),
      .presetn       (presetn),
      .pos_opened_in (pos_opened_in),
      .pos_closed_in (pos_closed_in),
      .p             (t.sup)
   );

   // pin synchronisers, one per input bit
   wire [6:0] pin_raw = {outside_command_seen, process_block, close_interlock_ok,
                         open_interlock_ok, sync_ok, remote_permit, local_permit};
   logic [6:0] sync_a;  // first stage, read only by sync_b
   logic [6:0] sync_b;  // usable copies
   generate
      for (genvar i = 0; i < 7; i++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync_a[i] <= 1'b0;
               sync_b[i] <= 1'b0;
            end else begin
               sync_a[i] <= pin_raw[i];
               sync_b[i] <= sync_a[i];
            end
         end
      end
   endgenerate
   wire loc_ok  = sync_b[0];
   wire rem_ok  = sync_b[1];
   wire syn_ok  = sync_b[2];
   wire ena_off = sync_b[3];
   wire ena_on  = sync_b[4];
   wire blk     = sync_b[5];
   wire ext_sw  = sync_b[6];

   // registers
   scheme_type  scheme;                  // control scheme
   logic        forced_chk;              // checks cannot be skipped
   logic [15:0] limit [`LIM_COUNT];      // ms limits
   logic [15:0] op_count;                // operation counter
   logic        err_inv;                 // sticky invalid position
   logic        err_rej;                 // sticky rejected request
   logic        err_self;                // sticky unintended operation
   state_type   state;                   // sequencer state
   logic [15:0] elapsed;                 // ms in current step
   logic        dir_close;               // command direction
   logic        chk_r;                   // checks applied to command
   logic [15:0] oper_ms;                 // operation pulse timer

   // apb decode
   wire wr      = psel && penable && pwrite;
   wire ctrl_wr = wr && (paddr == `REG_CTRL);
   wire cmd_wr  = wr && (paddr == `REG_CMD);
   wire stat_wr = wr && (paddr == `REG_STATUS);
   wire lim_hit = (paddr >= `REG_LIM_BASE) && (paddr <= `REG_LIM_LAST) && (paddr[1:0] == 2'h0);
   wire [2:0] lim_idx = 3'((paddr - `REG_LIM_BASE) >> 2);
   wire addr_ok = lim_hit || paddr == `REG_CTRL || paddr == `REG_CMD
                  || paddr == `REG_STATUS || paddr == `REG_OPCNT;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   wire [15:0] pulse_len = limit[`LIM_PULSE];
   wire [15:0] max_op    = limit[`LIM_MAXOP];
   wire [15:0] sync_lim  = limit[`LIM_SYNCW];
   wire [15:0] sw_lim    = limit[`LIM_SWW];
   wire [15:0] sel_lim   = limit[`LIM_SELH];
   assign t.inter_limit  = limit[`LIM_INTER];
   assign t.tmr_clr      = ctrl_wr && pwdata[`CTRL_TMR_CLR];
   assign pos_status     = t.pos_status;

   // request evaluation
   wire rq_open   = pwdata[`CMD_OPEN];
   wire rq_close  = pwdata[`CMD_CLOSE];
   wire rq_sel    = pwdata[`CMD_SELECT];
   wire rq_any    = cmd_wr && (rq_open || rq_close);
   wire permit    = pwdata[`CMD_REMOTE] ? rem_ok : loc_ok;           // RQ1 RQ2
   wire check     = forced_chk || !pwdata[`CMD_SKIP_CHK];            // RQ8
   wire idle_like = (state == ST_IDLE) || (state == ST_SELECTED);    // RQ23
   wire sbo       = (scheme == SBO_ENH);
   wire enh       = (scheme != DIRECT_NORMAL);
   wire lock_ok   = rq_open ? (!check || ena_off) : (!check || ena_on); // RQ3 RQ4
   wire base_ok   = rq_any && idle_like && permit && !blk && (rq_open ^ rq_close) && lock_ok;
   wire sel_go    = base_ok && sbo && rq_sel && state == ST_IDLE;   // RQ16
   wire oper_ok   = sbo ? (state == ST_SELECTED && !rq_sel && rq_close == dir_close)
                        : (state == ST_IDLE && !rq_sel);
   wire go        = base_ok && oper_ok;
   wire rejected  = rq_any && !go && !sel_go;                        // RQ5 RQ23
   wire need_sync = rq_close && check && !syn_ok;                    // RQ6
   wire success   = dir_close ? (t.pos_status == POS_ON) : (t.pos_status == POS_OFF);
   wire pulse_end = (elapsed >= pulse_len) || (success && elapsed >= `MIN_PULSE_MS);
   wire op_late   = enh && !success && (elapsed >= max_op);          // RQ9
   wire cmd_act   = (state == ST_PULSE) || (state == ST_SUPERVISE);

   // next state
   state_type next_state;
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (sel_go)
               next_state = ST_SELECTED;
            else if (go)
               next_state = need_sync ? ST_SYNC_WAIT : ST_PULSE;    // RQ13
         end
         ST_SELECTED: begin
            if (go)
               next_state = need_sync ? ST_SYNC_WAIT : ST_PULSE;
            else if (blk || elapsed >= sel_lim)
               next_state = ST_IDLE;                                 // RQ16
         end
         ST_SYNC_WAIT: begin
            if (blk)
               next_state = ST_IDLE;
            else if (syn_ok)
               next_state = ST_PULSE;
            else if (elapsed >= sync_lim)
               next_state = (sw_lim == 16'h0000) ? ST_IDLE : ST_SW_WAIT; // RQ13 RQ15
         end
         ST_SW_WAIT: begin
            if (blk || elapsed >= sw_lim)
               next_state = ST_IDLE;                                 // RQ14
            else if (syn_ok)
               next_state = ST_PULSE;
         end
         ST_PULSE: begin
            if (blk)
               next_state = ST_IDLE;                                 // RQ5
            else if (pulse_end)
               next_state = (enh && !success && !op_late) ? ST_SUPERVISE : ST_IDLE; // RQ11
         end
         ST_SUPERVISE: begin
            if (success || op_late)
               next_state = ST_IDLE;                                 // RQ9
         end
         default: next_state = ST_IDLE;
      endcase
   end

   wire leave_late = op_late && ((state == ST_SUPERVISE)
                     || (state == ST_PULSE && pulse_end && !blk));
   wire keep_time  = (state == ST_PULSE) && (next_state == ST_SUPERVISE);
   wire next_open  = (next_state == ST_PULSE) && !dir_close && !blk
                     && (!chk_r || ena_off);                         // RQ3 RQ5
   wire next_close = (next_state == ST_PULSE) && dir_close && !blk
                     && (!chk_r || ena_on);                          // RQ4 RQ5

   // sequencer state and step timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= ST_IDLE;
         elapsed <= 16'h0000;
      end else if (t.tmr_clr) begin
         state   <= ST_IDLE;     // RQ22
         elapsed <= 16'h0000;
      end else begin
         state <= next_state;
         if (next_state != state && !keep_time)
            elapsed <= 16'h0000;
         else if (t.tick && elapsed != 16'hFFFF)
            elapsed <= elapsed + 16'h0001; // RQ22
      end
   end

   // command capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_close <= 1'b0;
         chk_r     <= 1'b1;
      end else if (go || sel_go) begin
         dir_close <= rq_close;
         chk_r     <= check;     // RQ8
      end
   end

   // breaker outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         open_pulse_out    <= 1'b0;
         close_pulse_out   <= 1'b0;
         sync_switch_start <= 1'b0;
      end else begin
         open_pulse_out    <= next_open;  // RQ10
         close_pulse_out   <= next_close; // RQ10
         sync_switch_start <= (next_state == ST_SW_WAIT) && (sw_lim != 16'h0000); // RQ15
      end
   end

   // operation pulse and counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oper_pulse <= 1'b0;
         oper_ms    <= 16'h0000;
         op_count   <= 16'h0000;
      end else begin
         if (t.moved) begin
            oper_pulse <= 1'b1;  // RQ19
            oper_ms    <= 16'h0000;
         end else if (t.tmr_clr || (oper_pulse && oper_ms >= `OPER_PULSE_MS)) begin
            oper_pulse <= 1'b0;
            oper_ms    <= 16'h0000;
         end else if (oper_pulse && t.tick)
            oper_ms <= oper_ms + 16'h0001;
         if (t.moved)
            op_count <= (ctrl_wr && pwdata[`CTRL_CNT_CLR]) ? 16'h0001 : op_count + 16'h0001; // RQ19
         else if (ctrl_wr && pwdata[`CTRL_CNT_CLR])
            op_count <= 16'h0000;
      end
   end

   // software settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scheme     <= DIRECT_NORMAL;  // RQ7
         forced_chk <= 1'b1;           // RQ8
      end else if (ctrl_wr) begin
         scheme     <= scheme_type'(pwdata[`CTRL_SCHEME_HI:`CTRL_SCHEME_LO]); // RQ7
         forced_chk <= pwdata[`CTRL_FORCED];
      end
   end

   // limit table, one word per entry
   localparam logic [15:0] LIM_DEF [`LIM_COUNT] = '{`PULSE_DEF, `MAXOP_DEF,
      `INTER_DEF, `SYNCW_DEF, `SWW_DEF, `SELH_DEF};
   generate
      for (genvar i = 0; i < `LIM_COUNT; i++) begin : g_lim
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
               limit[i] <= LIM_DEF[i];
            else if (wr && lim_hit && lim_idx == 3'(i))
               limit[i] <= pwdata[15:0];
         end
      end
   endgenerate

   // sticky flags, set wins over write-one-to-clear
   wire self_set = t.moved && !cmd_act && !ext_sw; // RQ17 RQ20
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_inv  <= 1'b0;
         err_rej  <= 1'b0;
         err_self <= 1'b0;
      end else begin
         err_inv  <= leave_late || (err_inv && !(stat_wr && pwdata[`ST_INV_POS])); // RQ9
         err_rej  <= rejected || (err_rej && !(stat_wr && pwdata[`ST_REJECT]));    // RQ23
         err_self <= self_set || (err_self && !(stat_wr && pwdata[`ST_UNINTENDED])); // RQ20
      end
   end
   assign unintended_operation = err_self;
   assign invalid_pos_err      = err_inv;

   // read data, latched in the setup cycle
   wire [31:0] stat_word = {21'h0, err_self, err_rej, err_inv, 3'h0,
                            state == ST_SELECTED, sync_switch_start, !idle_like,
                            t.pos_status};
   wire [31:0] rd_data =
      (paddr == `REG_CTRL)   ? {27'h0, 2'h0, forced_chk, scheme} :
      (paddr == `REG_STATUS) ? stat_word :
      (paddr == `REG_OPCNT)  ? {16'h0, op_count} :
      lim_hit                ? {16'h0, limit[lim_idx]} : 32'h0000_0000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable)
         prdata <= rd_data;
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   local_gate_a: assert property (cmd_wr && !pwdata[`CMD_REMOTE] && !loc_ok && state == ST_IDLE
      |=> state == $past(state)) else $error("local request taken without permit"); // RQ1
   remote_gate_a: assert property (cmd_wr && pwdata[`CMD_REMOTE] && !rem_ok && state == ST_IDLE
      |=> state == $past(state)) else $error("remote request taken without permit"); // RQ2
   open_lock_a: assert property (open_pulse_out |-> $past(ena_off) || !$past(chk_r))
      else $error("open pulse without interlock"); // RQ3
   close_lock_a: assert property (close_pulse_out |-> $past(ena_on) || !$past(chk_r))
      else $error("close pulse without interlock"); // RQ4
   block_quiet_a: assert property (blk |=> !open_pulse_out && !close_pulse_out)
      else $error("pulse while blocked"); // RQ5
   sync_enter_a: assert property (state == ST_IDLE && go && rq_close && check && !syn_ok
      && !t.tmr_clr |=> state == ST_SYNC_WAIT) else $error("close skipped sync wait"); // RQ6
   no_sw_start_a: assert property ($past(sw_lim) == 16'h0000 |-> !sync_switch_start)
      else $error("switch start with zero limit"); // RQ15
   pulse_len_a: assert property (state == ST_PULSE |-> elapsed <= pulse_len)
      else $error("pulse overran its length"); // RQ10
   pulse_min_a: assert property ($past(state) == ST_PULSE && state != ST_PULSE
      && !$past(blk) && !$past(t.tmr_clr)
      |-> $past(elapsed) >= `MIN_PULSE_MS || $past(elapsed) >= $past(pulse_len))
      else $error("pulse ended below minimum"); // RQ11
   busy_reject_a: assert property (rq_any && !idle_like |=> err_rej)
      else $error("busy request not rejected"); // RQ23
   oper_start_a: assert property (t.moved |=> oper_pulse [*2])
      else $error("operation pulse missing"); // RQ19
   select_drop_a: assert property (state == ST_SELECTED && elapsed >= sel_lim && !go
      && !t.tmr_clr |=> state == ST_IDLE) else $error("selection not dropped"); // RQ16

   close_seen_c: cover property (close_pulse_out && state == ST_PULSE);
   sw_wait_c: cover property (sync_switch_start);
   inv_pos_c: cover property ($rose(err_inv));
   sbo_go_c: cover property (state == ST_SELECTED ##1 state == ST_PULSE);
endmodule

// ---- breaker_model.sv ----
// breaker model: two contacts that follow the command coils
// assumes: coil pulses are levels sampled on pclk
`timescale 1ns/10ps
module breaker_model (
   input  wire logic pclk,
   input  wire logic open_pulse_out,
   input  wire logic close_pulse_out,
   output logic      pos_opened_in = 1'b1,
   output logic      pos_closed_in = 1'b0
);
   logic [7:0] travel   = 8'h00; // cycles of contact travel left
   logic       to_close = 1'b0;  // direction of travel
   // both contacts low in travel, then the new end contact
   always @(posedge pclk) begin
      if (travel == 8'h01)
         {pos_opened_in, pos_closed_in} <= {~to_close, to_close};
      if (travel != 8'h00)
         travel <= travel - 8'h01;
      else if (open_pulse_out != close_pulse_out && close_pulse_out != pos_closed_in) begin
         to_close <= close_pulse_out;
         {pos_opened_in, pos_closed_in} <= 2'b00;
         travel <= 8'h50;
      end
   end
endmodule

// ---- brk_defines.svh ----
// named constants for the breaker command control block
// assumes: included by bare name, timing, limit and register numbers live here
`ifndef BRK_DEFINES_SVH
`define BRK_DEFINES_SVH

// clock and millisecond tick
`define CLK_PERIOD_NS   40
`define TICK_PERIOD_NS  1000000
`define TICK_CYCLES     (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// fixed times in ms
`define MIN_PULSE_MS    16'h0064
`define OPER_PULSE_MS   16'h0096

// limit defaults in ms
`define PULSE_DEF       16'h012C
`define MAXOP_DEF       16'h00C8
`define INTER_DEF       16'h0064
`define SYNCW_DEF       16'h03E8
`define SWW_DEF         16'h0000
`define SELH_DEF        16'h1388

// limit table index
`define LIM_PULSE       0
`define LIM_MAXOP       1
`define LIM_INTER       2
`define LIM_SYNCW       3
`define LIM_SWW         4
`define LIM_SELH        5
`define LIM_COUNT       6

// register byte offsets
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_STATUS      8'h08
`define REG_OPCNT       8'h0C
`define REG_LIM_BASE    8'h10
`define REG_LIM_LAST    8'h24

// control fields
`define CTRL_SCHEME_HI  1
`define CTRL_SCHEME_LO  0
`define CTRL_FORCED     2
`define CTRL_TMR_CLR    3
`define CTRL_CNT_CLR    4

// command fields
`define CMD_OPEN        0
`define CMD_CLOSE       1
`define CMD_REMOTE      2
`define CMD_SELECT      3
`define CMD_SKIP_CHK    4

// status fields
`define ST_POS_HI       1
`define ST_POS_LO       0
`define ST_BUSY         2
`define ST_SW_START     3
`define ST_SELECTED     4
`define ST_INV_POS      8
`define ST_REJECT       9
`define ST_UNINTENDED   10

`endif

// ---- brk_pkg.sv ----
// types shared by the breaker command control block
// assumes: compiled before every other file of the block
package brk_pkg;

   // filtered breaker position
   typedef enum logic [1:0] {
      POS_INTER = 2'h0,
      POS_OFF   = 2'h1,
      POS_ON    = 2'h2,
      POS_BAD   = 2'h3
   } pos_status_type;

   // control scheme selection
   typedef enum logic [1:0] {
      DIRECT_NORMAL = 2'h0,
      DIRECT_ENH    = 2'h1,
      SBO_ENH       = 2'h2
   } scheme_type;

   // command sequencer, one-hot
   typedef enum logic [5:0] {
      ST_IDLE      = 6'h01,
      ST_SELECTED  = 6'h02,
      ST_SYNC_WAIT = 6'h04,
      ST_SW_WAIT   = 6'h08,
      ST_PULSE     = 6'h10,
      ST_SUPERVISE = 6'h20
   } state_type;

endpackage

// ---- brk_time_if.sv ----
// tick and position signals between the block's own modules
// assumes: one instance inside the top module
`timescale 1ns/10ps
interface brk_time_if;
   import brk_pkg::*;
   logic           tick;        // one-cycle ms tick
   logic           tmr_clr;     // synchronous timer clear
   logic [15:0]    inter_limit; // intermediate wait in ms
   pos_status_type pos_status;  // filtered position
   logic           moved;       // pulse on a new valid position

   modport gen (output tick, input tmr_clr);
   modport sup (input tick, tmr_clr, inter_limit, output pos_status, moved);
   modport ctl (input tick, pos_status, moved, output tmr_clr, inter_limit);
endinterface

// ---- ms_tick_gen.sv ----
// millisecond tick enable from the system clock
// assumes: pclk at the period set in the defines header
`timescale 1ns/10ps
`include "brk_defines.svh"
module ms_tick_gen #(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   input  wire logic pclk,
   input  wire logic presetn,
   brk_time_if.gen   t
);
   import brk_pkg::*;

   logic [15:0] div;  // cycle divider
   wire         wrap = (div == 16'(TICK_CYCLES - 1));

   // free divider, cleared by the timer clear (RQ22)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div    <= 16'h0000;
         t.tick <= 1'b0;
      end else if (t.tmr_clr) begin
         div    <= 16'h0000; // RQ22
         t.tick <= 1'b0;
      end else begin
         div    <= wrap ? 16'h0000 : div + 16'h0001;
         t.tick <= wrap;
      end
   end
endmodule

// ---- pos_supervisor.sv ----
// position input synchroniser, filter and four-valued status
// assumes: two separate contacts, opened and closed, from the breaker
`timescale 1ns/10ps
`include "brk_defines.svh"
module pos_supervisor (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pos_opened_in,
   input  wire logic pos_closed_in,
   brk_time_if.sup   p
);
   import brk_pkg::*;

   logic [1:0]     sync_a;     // first stage, read only by sync_b
   logic [1:0]     sync_b;     // {closed, opened} in pclk domain
   logic [1:0]     raw_prev;   // last sampled raw pair
   logic [15:0]    hold;       // ms spent in a non-valid pair
   pos_status_type last_valid; // last reported valid position

   // raw status from the two contacts (RQ18)
   wire pos_status_type raw = pos_status_type'(sync_b); // RQ21
   wire raw_valid = (raw == POS_OFF) || (raw == POS_ON);
   wire hold_done = (hold >= p.inter_limit);
   wire pos_status_type next_filt = (raw_valid || hold_done) ? raw : p.pos_status;
   wire next_valid = (next_filt == POS_OFF) || (next_filt == POS_ON);

   // two-stage synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 2'h0;
         sync_b <= 2'h0;
      end else begin
         sync_a <= {pos_closed_in, pos_opened_in};
         sync_b <= sync_a;
      end
   end

   // intermediate / bad hold timer (RQ12)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold     <= 16'h0000;
         raw_prev <= 2'h0;
      end else begin
         raw_prev <= sync_b;
         if (p.tmr_clr || raw_valid || sync_b != raw_prev)
            hold <= 16'h0000; // RQ22
         else if (p.tick && !hold_done)
            hold <= hold + 16'h0001; // RQ12
      end
   end

   // filtered status and movement pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p.pos_status <= POS_INTER;
         last_valid   <= POS_INTER;
         p.moved      <= 1'b0;
      end else begin
         p.pos_status <= next_filt; // RQ21
         if (next_valid)
            last_valid <= next_filt;
         p.moved <= next_valid && (last_valid != POS_INTER) && (next_filt != last_valid);
      end
   end
endmodule

// ---- test_breaker_command_control.sv ----
// testbench: apb master, breaker model, five scenarios
// assumes: tick shortened to 4 cycles per ms
`timescale 1ns/10ps
module test_breaker_command_control;
   import brk_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        local_permit, remote_permit, sync_ok, process_block, outside_command_seen;
   logic        open_interlock_ok, close_interlock_ok, pos_opened_in, pos_closed_in;
   logic        open_pulse_out, close_pulse_out, sync_switch_start, oper_pulse;
   logic        unintended_operation, invalid_pos_err;
   pos_status_type pos_status;
   int          n_errors = 0, check_count = 0, len;
   breaker_command_control #(.TICK_CYCLES(4)) breaker_command_control_i (.*);
   breaker_model breaker_model_i (.*);
   // free-running bus clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, answer taken at the pready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      if (n >= 20) begin
         n_errors++;
         finish_test();
      end
   endtask
   // cycles that a coil output stays high after a command
   task automatic measure(input logic cl);
      len = 0;
      repeat (8) if ((cl ? close_pulse_out : open_pulse_out) !== 1'b1) @(posedge pclk);
      while ((cl ? close_pulse_out : open_pulse_out) === 1'b1 && len < 5000) begin
         @(posedge pclk);
         len++;
      end
   endtask
   task automatic t_reset;
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("ctrl", 32'h0000_0004, rd);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("pulse limit", 32'h0000_012C, rd);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, {31'h0, err});
      $display("test reset done");
   endtask
   task automatic t_close;
      apb(1'b1, 8'h04, 32'h0000_0002);
      measure(1'b1);
      chk("close len ok", 32'h0000_0001, {31'h0, len >= 396 && len <= 408});
      chk("oper pulse", 32'h0000_0001, {31'h0, oper_pulse});
      repeat (700) @(posedge pclk);
      chk("oper end", 32'h0000_0000, {31'h0, oper_pulse});
      chk("pos on", {30'h0, POS_ON}, {30'h0, pos_status});
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("op count", 32'h0000_0001, rd);
      $display("test close done");
   endtask
   // each refusal: no coil pulse and the reject flag set
   task automatic refuse(input string nm, input logic [31:0] cmd);
      apb(1'b1, 8'h08, 32'h0000_0200);
      apb(1'b1, 8'h04, cmd);
      measure(cmd[1]);
      chk(nm, 32'h0000_0000, len);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk("reject flag", 32'h0000_0001, {31'h0, rd[9]});
   endtask
   task automatic t_refuse;
      local_permit <= 1'b0;
      refuse("no local", 32'h0000_0001);
      local_permit <= 1'b1;
      refuse("no remote", 32'h0000_0005);
      process_block <= 1'b1;
      refuse("blocked", 32'h0000_0001);
      {process_block, open_interlock_ok} <= 2'b00;
      refuse("open locked", 32'h0000_0001);
      open_interlock_ok <= 1'b1;
      $display("test refuse done");
   endtask
   task automatic t_open;
      remote_permit <= 1'b1;
      apb(1'b1, 8'h04, 32'h0000_0005);
      measure(1'b0);
      chk("open len ok", 32'h0000_0001, {31'h0, len >= 396 && len <= 408});
      $display("test open done");
   endtask
   // close without sync: busy request refused, wait expires to idle
   task automatic t_sync;
      sync_ok <= 1'b0;
      apb(1'b1, 8'h08, 32'h0000_0200);
      apb(1'b1, 8'h04, 32'h0000_0002);
      apb(1'b1, 8'h04, 32'h0000_0001);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk("sync wait busy", 32'h0000_0204, rd & 32'h0000_020C);
      repeat (4100) @(posedge pclk);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk("sync expiry", 32'h0000_0201, rd & 32'h0000_070F);
      sync_ok <= 1'b1;
      $display("test sync done");
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {local_permit, remote_permit, sync_ok, process_block, outside_command_seen} = 5'b10100;
      {open_interlock_ok, close_interlock_ok} = 2'b11;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_close();
      t_refuse();
      t_open();
      t_sync();
      finish_test();
   end
endmodule
